// >>> rtcc_defines.svh
// Offsets, field positions, reset values and timing counts for the RTC control block.
// Assumes it is included by its bare name into every file that needs these values.
`ifndef RTCC_DEFINES_SVH
`define RTCC_DEFINES_SVH

`define RTCC_CTRL_OFS 12'h000
`define RTCC_TIME_OFS 12'h010
`define RTCC_KEY_OFS 12'h020

`define RTCC_ON_BIT 15
`define RTCC_WREN_BIT 3
`define RTCC_SYNC_BIT 2
`define RTCC_HALF_BIT 1
`define RTCC_OE_BIT 0
`define RTCC_SEC_MSB 14
`define RTCC_SEC_LSB 8
`define RTCC_SEC_LAST 7'h3B

`define RTCC_KEY_FIRST 32'h0000_00A5
`define RTCC_KEY_SECOND 32'h0000_005A

`define RTCC_CTRL_RESET 32'h0000_0000
`define RTCC_TIME_RESET 32'h0000_0000

`define RTCC_CLK_PERIOD_NS 4
`define RTCC_HALF_SEC_NS 500000000
`define RTCC_SYNC_WINDOW_NS 128
`define RTCC_HALF_SEC_CYC (`RTCC_HALF_SEC_NS / `RTCC_CLK_PERIOD_NS)
`define RTCC_SYNC_WINDOW_CYC ((`RTCC_SYNC_WINDOW_NS + `RTCC_CLK_PERIOD_NS - 1) / `RTCC_CLK_PERIOD_NS)

`endif

// >>> rtcc_pkg.sv
// Types shared by the RTC control block.
// Assumes the defines header supplies all numeric constants.
package rtcc_pkg;
    typedef logic [31:0] rtcc_word_t;
    typedef logic [11:0] rtcc_addr_t;

    typedef struct packed {
        logic on;
        logic wren;
        logic oe;
    } rtcc_ctrl_t;

    typedef enum logic [0:0] {
        KEY_IDLE = 1'b0,
        KEY_HALF = 1'b1
    } rtcc_key_state_t;
endpackage : rtcc_pkg

// >>> rtcc_sec_timer.sv
// Second phase counter giving the half-second flag, the rollover strobe and the read-sync window.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "rtcc_defines.svh"
module rtcc_sec_timer #(
    parameter int unsigned HALF_CYC = `RTCC_HALF_SEC_CYC,
    parameter int unsigned SYNC_CYC = `RTCC_SYNC_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic restart,
    output logic half_second_flag,
    output logic syncWin,
    output logic secWrap
);
    import rtcc_pkg::*;

    localparam logic [31:0] LAST_CNT = 32'(2 * HALF_CYC - 1);
    localparam logic [31:0] HALF_CNT = 32'(HALF_CYC);
    localparam logic [31:0] SYNC_START = 32'(2 * HALF_CYC - SYNC_CYC);

    generate
        if (HALF_CYC < 2 || SYNC_CYC < 1 || SYNC_CYC > HALF_CYC) begin : g_bad
            $error("rtcc_sec_timer: sync window must fit inside half a second");
        end
    endgenerate

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic half_second_flag_q;
    logic syncWin_q;

    assign secWrap = run & ~restart & (cnt_q == LAST_CNT);

    always_comb begin
        if (restart || !run || secWrap) begin
            cnt_d = 32'h0000_0000;
        end else begin
            cnt_d = cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 32'h0000_0000;
            half_second_flag_q <= 1'b0;
            syncWin_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            half_second_flag_q <= (cnt_d >= HALF_CNT);
            syncWin_q <= run & (cnt_d >= SYNC_START);
        end
    end

    assign half_second_flag = half_second_flag_q;
    assign syncWin = syncWin_q;
endmodule : rtcc_sec_timer

// >>> rtcc_control.sv
// RTC control register, time value register, write unlock and clock output over APB.
// Assumes an APB master on clk; sys_rst is the power-on reset, otherRst any lesser reset.
// What this block does
// - Time value writes take effect only while the value write enable bit is set.
// - Read-sync flag is high while time values may ripple at rollover.
// - Half-second bit reads high in the second half of each second.
// - Writing the seconds field clears the half-second bit.
// - Clock output pin is driven only while clock output enable is set.
// - The ON bit changes only while value write enable is set.
// - Value write enable can be set only after the unlock sequence.
// - Control register resets only on power-on reset.
`timescale 1ns/10ps
`include "rtcc_defines.svh"
module rtcc_control #(
    parameter int unsigned HALF_CYC = `RTCC_HALF_SEC_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic otherRst,
    input wire rtcc_pkg::rtcc_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire rtcc_pkg::rtcc_word_t pwdata,
    output rtcc_pkg::rtcc_word_t prdata,
    output logic pready,
    output logic pslverr,
    output logic clkOutPin,
    output logic clkOutPinEn
);
    import rtcc_pkg::*;

    localparam int unsigned SYNC_CYC = `RTCC_SYNC_WINDOW_CYC;
    localparam rtcc_word_t CTRL_RST = `RTCC_CTRL_RESET;

    rtcc_ctrl_t ctrl_q;
    rtcc_word_t time_q;
    rtcc_word_t prdata_q;
    rtcc_key_state_t keyState_q;
    logic seqEn_q;
    logic pready_q;
    logic pslverr_q;
    logic clkOutPin_q;
    logic clkOutPinEn_q;
    logic half_second_flag;
    logic syncFlag;
    logic secWrap;
    logic hitCtrl;
    logic hitTime;
    logic hitKey;
    logic wrDone;
    logic wrCtrl;
    logic wrTime;
    logic wrKey;
    logic timeAccept;
    logic [6:0] secNow;
    rtcc_word_t rdMux;

    assign hitCtrl = (paddr == `RTCC_CTRL_OFS);
    assign hitTime = (paddr == `RTCC_TIME_OFS);
    assign hitKey = (paddr == `RTCC_KEY_OFS);
    assign wrDone = psel & penable & pready_q & pwrite;
    assign wrCtrl = wrDone & hitCtrl;
    assign wrTime = wrDone & hitTime;
    assign wrKey = wrDone & hitKey;
    assign timeAccept = wrTime & ctrl_q.wren;
    assign secNow = time_q[`RTCC_SEC_MSB:`RTCC_SEC_LSB];

    rtcc_sec_timer #(
        .HALF_CYC(HALF_CYC),
        .SYNC_CYC(SYNC_CYC)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(ctrl_q.on),
        .restart(timeAccept),
        .half_second_flag(half_second_flag),
        .syncWin(syncFlag),
        .secWrap(secWrap)
    );

    // Read data, with the status bits taken live from the timer.
    always_comb begin
        rdMux = 32'h0000_0000;
        if (hitCtrl) begin
            rdMux[`RTCC_ON_BIT] = ctrl_q.on;
            rdMux[`RTCC_WREN_BIT] = ctrl_q.wren;
            rdMux[`RTCC_SYNC_BIT] = syncFlag;
            rdMux[`RTCC_HALF_BIT] = half_second_flag;
            rdMux[`RTCC_OE_BIT] = ctrl_q.oe;
        end else if (hitTime) begin
            rdMux = time_q;
        end
    end

    // APB slave: the answer comes in the first access cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel & ~penable;
            if (psel && !penable) begin
                pslverr_q <= ~(hitCtrl | hitTime | hitKey);
                prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Control register, cleared by power-on reset only.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q.on <= CTRL_RST[`RTCC_ON_BIT];
            ctrl_q.wren <= CTRL_RST[`RTCC_WREN_BIT];
            ctrl_q.oe <= CTRL_RST[`RTCC_OE_BIT];
        end else if (wrCtrl) begin
            if (ctrl_q.wren) begin
                ctrl_q.on <= pwdata[`RTCC_ON_BIT];
            end
            if (!pwdata[`RTCC_WREN_BIT]) begin
                ctrl_q.wren <= 1'b0;
            end else if (seqEn_q) begin
                ctrl_q.wren <= 1'b1;
            end
            ctrl_q.oe <= pwdata[`RTCC_OE_BIT];
        end
    end

    // Unlock sequence: two key words written back to back to the key register.
    always_ff @(posedge clk) begin
        if (sys_rst || otherRst) begin
            keyState_q <= KEY_IDLE;
            seqEn_q <= 1'b0;
        end else if (wrKey) begin
            unique case (keyState_q)
                KEY_IDLE: begin
                    keyState_q <= (pwdata == `RTCC_KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                    seqEn_q <= 1'b0;
                end
                KEY_HALF: begin
                    keyState_q <= KEY_IDLE;
                    seqEn_q <= (pwdata == `RTCC_KEY_SECOND);
                end
            endcase
        end
    end

    // Time value register: software write wins over the hardware seconds count.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            time_q <= `RTCC_TIME_RESET;
        end else if (timeAccept) begin
            time_q <= pwdata;
        end else if (secWrap) begin
            time_q[`RTCC_SEC_MSB:`RTCC_SEC_LSB] <= (secNow >= `RTCC_SEC_LAST) ? 7'h00 : secNow + 7'h01;
        end
    end

    // Clock output pin follows the half-second wave.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkOutPin_q <= 1'b0;
            clkOutPinEn_q <= 1'b0;
        end else begin
            clkOutPin_q <= half_second_flag & ctrl_q.on;
            clkOutPinEn_q <= ctrl_q.oe & ctrl_q.on;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign clkOutPin = clkOutPin_q;
    assign clkOutPinEn = clkOutPinEn_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence apbSetup;
        psel && !penable;
    endsequence

    sequence apbAccess;
        psel && penable && pready;
    endsequence

    AST_APB_ONE_WAIT: assert property (apbSetup ##1 (psel && penable) |-> apbAccess)
        else $error("Access phase did not complete in its first cycle.");

    AST_TIME_LOCKED: assert property (wrTime && !ctrl_q.wren && !secWrap |=> time_q == $past(time_q))
        else $error("Locked time value register changed on a write.");

    AST_TIME_WRITTEN: assert property (wrTime && ctrl_q.wren |=> time_q == $past(pwdata))
        else $error("Unlocked time value write was not stored.");

    AST_SYNC_AT_WRAP: assert property (secWrap |-> syncFlag ##1 !syncFlag)
        else $error("Read-sync flag not framing the rollover.");

    AST_SYNC_WINDOW: assert property (disable iff (sys_rst || timeAccept || !ctrl_q.on) $rose(syncFlag) |-> syncFlag [*8])
        else $error("Read-sync window shorter than expected.");

    AST_HALF_ZERO_AFTER_WRAP: assert property (secWrap |=> !half_second_flag)
        else $error("Half-second bit high at start of a second.");

    AST_HALF_CLEARED: assert property (timeAccept |=> !half_second_flag [*2])
        else $error("Half-second bit not cleared by a seconds write.");

    AST_PIN_OFF: assert property (!ctrl_q.oe |=> !clkOutPinEn)
        else $error("Clock output enabled while output enable is clear.");

    AST_ON_LOCKED: assert property (wrCtrl && !ctrl_q.wren |=> ctrl_q.on == $past(ctrl_q.on))
        else $error("ON bit changed while write enable was clear.");

    AST_WREN_NEEDS_SEQ: assert property (wrCtrl && pwdata[`RTCC_WREN_BIT] && !seqEn_q && !ctrl_q.wren |=> !ctrl_q.wren)
        else $error("Write enable set without unlock sequence.");

    AST_WREN_CLEAR: assert property (wrCtrl && !pwdata[`RTCC_WREN_BIT] |=> !ctrl_q.wren)
        else $error("Write enable did not clear.");

    AST_CTRL_KEEPS: assert property (otherRst && !wrCtrl |=> ctrl_q == $past(ctrl_q))
        else $error("Control register disturbed by a non power-on reset.");
endmodule : rtcc_control

// >>> test_rtc_control_lock_and_status.sv
// Self-checking bench for the RTC control block, driven over APB.
// Assumes the defines header and package are compiled first; the second is shortened to 128 cycles.
`timescale 1ns/10ps
`include "rtcc_defines.svh"
module test_rtc_control_lock_and_status;
    import rtcc_pkg::*;
    typedef struct packed {
        logic wr;
        rtcc_addr_t addr;
        rtcc_word_t wd;
        rtcc_word_t mask;
        rtcc_word_t exp;
        logic err;
    } rtcc_tbrow_t;
    localparam int unsigned HC = 64;
    localparam rtcc_addr_t C = `RTCC_CTRL_OFS;
    localparam rtcc_addr_t T = `RTCC_TIME_OFS;
    localparam rtcc_addr_t K = `RTCC_KEY_OFS;
    localparam rtcc_word_t F = 32'hFFFF_FFFF;
    localparam rtcc_word_t N = 32'hFFFF_FFF9;
    localparam rtcc_word_t S = 32'hFFFF_80FF;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic otherRst = 1'b0;
    rtcc_addr_t paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    rtcc_word_t pwdata = 32'h0000_0000;
    rtcc_word_t prdata;
    logic pready;
    logic pslverr;
    logic clkOutPin;
    logic clkOutPinEn;
    rtcc_word_t rd;
    rtcc_word_t rdPrev;
    logic err;
    int fail_count = 0;
    int n_compared = 0;
    int hi;
    int lo;
    rtcc_tbrow_t rows [21] = '{
        '{1'b0, C, '0, F, `RTCC_CTRL_RESET, 1'b0},
        '{1'b0, T, '0, F, `RTCC_TIME_RESET, 1'b0},
        '{1'b1, C, 32'h0000_0008, '0, '0, 1'b0},
        '{1'b0, C, '0, 32'h0000_0008, '0, 1'b0},
        '{1'b1, T, 32'h00AB_0500, '0, '0, 1'b0},
        '{1'b0, T, '0, F, '0, 1'b0},
        '{1'b1, K, `RTCC_KEY_FIRST, '0, '0, 1'b0},
        '{1'b1, K, `RTCC_KEY_SECOND, '0, '0, 1'b0},
        '{1'b1, C, 32'h0000_0008, '0, '0, 1'b0},
        '{1'b0, C, '0, N, 32'h0000_0008, 1'b0},
        '{1'b1, T, 32'h00AB_0500, '0, '0, 1'b0},
        '{1'b0, T, '0, F, 32'h00AB_0500, 1'b0},
        '{1'b1, C, 32'h0000_8009, '0, '0, 1'b0},
        '{1'b0, C, '0, N, 32'h0000_8009, 1'b0},
        '{1'b1, C, 32'h0000_8001, '0, '0, 1'b0},
        '{1'b1, C, 32'h0000_0001, '0, '0, 1'b0},
        '{1'b0, C, '0, N, 32'h0000_8001, 1'b0},
        '{1'b1, T, '0, '0, '0, 1'b0},
        '{1'b0, T, '0, S, 32'h00AB_0000, 1'b0},
        '{1'b0, 12'h030, '0, F, '0, 1'b1},
        '{1'b1, 12'h030, 32'h0000_0001, '0, '0, 1'b1}
    };

    rtcc_control #(.HALF_CYC(HC)) dut (.clk(clk), .sys_rst(sys_rst), .otherRst(otherRst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clkOutPin(clkOutPin), .clkOutPinEn(clkOutPinEn));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk_word(input rtcc_word_t got, input rtcc_word_t exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic bus(input logic wr, input rtcc_addr_t a, input rtcc_word_t wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk_bit(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].addr, rows[i].wd);
            chk_word(rd & rows[i].mask, rows[i].exp);
            chk_bit(err, rows[i].err);
        end
        $display("done: register table");
        chk_bit(clkOutPinEn, 1'b1);
        hi = 0;
        repeat (4 * HC) begin
            @(posedge clk);
            hi += (clkOutPin === 1'b1);
        end
        chk_word(hi, 2 * HC);
        hi = 0;
        lo = 0;
        repeat (100) begin
            bus(1'b0, C, '0);
            lo += (rd[`RTCC_HALF_BIT] === 1'b0);
            if (rd[`RTCC_SYNC_BIT] === 1'b1) begin
                hi++;
                chk_bit(rd[`RTCC_HALF_BIT], 1'b1);
                bus(1'b0, T, '0);
                rdPrev = rd;
                bus(1'b0, T, '0);
                if (rd !== rdPrev) begin
                    rdPrev = rd;
                    bus(1'b0, T, '0);
                end
                chk_word(rd, rdPrev);
            end
        end
        chk_bit(hi > 0, 1'b1);
        chk_bit(lo > 0, 1'b1);
        $display("done: half second and read sync");
        bus(1'b1, K, `RTCC_KEY_FIRST);
        bus(1'b1, K, `RTCC_KEY_SECOND);
        bus(1'b1, C, 32'h0000_8009);
        hi = 0;
        do begin
            bus(1'b0, C, '0);
            hi++;
        end while (rd[`RTCC_HALF_BIT] !== 1'b1 && hi < 100);
        chk_bit(rd[`RTCC_HALF_BIT], 1'b1);
        bus(1'b1, T, 32'h0000_0700);
        bus(1'b0, C, '0);
        chk_bit(rd[`RTCC_HALF_BIT], 1'b0);
        chk_bit(clkOutPin, 1'b0);
        bus(1'b0, T, '0);
        chk_word(rd, 32'h0000_0700);
        bus(1'b1, C, 32'h0000_8008);
        repeat (2) @(posedge clk);
        chk_bit(clkOutPinEn, 1'b0);
        $display("done: seconds write and output enable");
        otherRst <= 1'b1;
        @(posedge clk);
        otherRst <= 1'b0;
        bus(1'b0, C, '0);
        chk_word(rd & N, 32'h0000_8008);
        bus(1'b1, C, 32'h0000_8000);
        bus(1'b1, C, 32'h0000_8008);
        bus(1'b0, C, '0);
        chk_word(rd & N, 32'h0000_8000);
        bus(1'b1, K, `RTCC_KEY_FIRST);
        bus(1'b1, K, `RTCC_KEY_SECOND);
        bus(1'b1, C, 32'h0000_0008);
        bus(1'b1, C, 32'h0000_0008);
        @(posedge clk);
        bus(1'b0, C, '0);
        chk_word(rd & N, 32'h0000_0008);
        chk_bit(clkOutPinEn, 1'b0);
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, C, '0);
        chk_word(rd, `RTCC_CTRL_RESET);
        chk_bit(clkOutPin, 1'b0);
        $display("done: resets");
        conclude();
    end
endmodule : test_rtc_control_lock_and_status
